// ---- rtl/dhs_pkg.sv ----
// Package for the dog-type homing sequencer: register map, field layouts, states.
// Assumes a single 50 MHz clock domain and an AHB-Lite register slave.
package dhs_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned POS_W = 32;
    localparam int unsigned SPD_W = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RAPID = 8'h04;
    localparam logic [7:0] OFS_HOME_RAPID = 8'h08;
    localparam logic [7:0] OFS_APPROACH = 8'h0C;
    localparam logic [7:0] OFS_SHIFT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_GRID_SPACE = 8'h18;
    localparam logic [7:0] OFS_MC_OFFSET = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_GRID_AMOUNT = 8'h24;
    localparam logic [7:0] OFS_MACHINE_POS = 8'h28;
    localparam logic [7:0] OFS_MOVE_CMD = 8'h2C;

    // Control register fields
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_ABORT_BIT = 1;
    localparam int unsigned CTRL_DIR_BIT = 2;
    localparam int unsigned CTRL_NOREF_BIT = 3;
    localparam int unsigned CTRL_HIGHSPEED_BIT = 4;
    localparam int unsigned CTRL_GRID_SEL_BIT = 6;
    localparam int unsigned CTRL_ERR_CLR_BIT = 7;

    // Status register fields
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_DONE_BIT = 1;
    localparam int unsigned ST_PROG_ERR_BIT = 2;
    localparam int unsigned ST_MOVING_BIT = 3;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] RAPID_RST = 16'h0100;
    localparam logic [15:0] HOME_RAPID_RST = 16'h0080;
    localparam logic [15:0] APPROACH_RST = 16'h0004;
    localparam logic [31:0] GRID_SPACE_RST = 32'h0000_1000;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum {
        DHS_IDLE,
        DHS_RAPID,
        DHS_DECEL,
        DHS_APPROACH,
        DHS_MASKED,
        DHS_SEEK_GRID,
        DHS_SHIFT,
        DHS_FAST_RETURN,
        DHS_DONE
    } dhs_state_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic prog_err;
        logic moving;
    } dhs_status_t;

    typedef struct packed {
        logic dir_neg;
        logic noref;
        logic high_speed_sel;
        logic grid_report_select;
    } dhs_cfg_t;

endpackage : dhs_pkg

// ---- rtl/dhs_homing_sequencer.sv ----
// Dog-type homing sequencer for one relative-encoder axis, with AHB-Lite registers.
// Assumes dog and Z-phase come from pins; position feedback is a count on this clock.
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module dhs_homing_sequencer #(
    parameter int unsigned POS_W = dhs_pkg::POS_W,
    parameter int unsigned SPD_W = dhs_pkg::SPD_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic dog_i,
    input wire logic zphase_i,
    input wire logic [POS_W-1:0] fb_pos_i,
    output logic [SPD_W-1:0] speed_cmd_o,
    output logic dir_neg_o,
    output logic [POS_W-1:0] pos_target_o,
    output logic pos_mode_o,
    output logic homed_o,
    output logic prog_err_o
);

    // Bus address phase capture
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] hrdata_reg;

    // Configuration
    dhs_pkg::dhs_cfg_t cfg_reg;
    logic [SPD_W-1:0] rapid_reg;
    logic [SPD_W-1:0] home_rapid_reg;
    logic [SPD_W-1:0] approach_reg;
    logic [POS_W-1:0] shift_reg;
    logic [POS_W-1:0] mask_reg;
    logic [POS_W-1:0] grid_space_reg;
    logic [POS_W-1:0] mc_offset_reg;
    logic start_reg;
    logic abort_reg;
    logic err_clr_reg;
    logic move_cmd_reg;

    // Sequencer state
    dhs_pkg::dhs_state_t state_reg;
    logic homed_reg;
    logic prog_err_reg;
    logic [POS_W-1:0] ref_pos_reg;
    logic [POS_W-1:0] rel_pos_reg;
    logic [POS_W-1:0] release_pos_reg;
    logic [POS_W-1:0] grid_amount_reg;
    logic [POS_W-1:0] machine_pos_reg;
    logic [POS_W-1:0] grid_phase_reg;
    logic [POS_W-1:0] last_fb_reg;

    // Pin synchronisers
    logic dog_meta_reg;
    logic dog_sync_reg;
    logic dog_prev_reg;
    logic z_meta_reg;
    logic z_sync_reg;
    logic z_prev_reg;

    logic bus_take;
    logic [POS_W-1:0] fb_delta;
    logic [POS_W-1:0] travel;
    logic grid_hit;
    logic z_rise;
    logic dog_fall;
    logic [POS_W-1:0] step_abs;
    logic [POS_W-1:0] phase_sum;
    logic [POS_W-1:0] fast_left;

    assign bus_take = hsel_i && hready_i && (htrans_i == dhs_pkg::HTRANS_NONSEQ);

    // Bus address phase; answer is zero wait state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= bus_take && hwrite_i;
            rd_pend_reg <= bus_take && !hwrite_i;
            if (bus_take) begin
                addr_reg <= haddr_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Register writes; command strobes last one cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= '0;
            rapid_reg <= SPD_W'(dhs_pkg::RAPID_RST);
            home_rapid_reg <= SPD_W'(dhs_pkg::HOME_RAPID_RST);
            approach_reg <= SPD_W'(dhs_pkg::APPROACH_RST);
            shift_reg <= '0;
            mask_reg <= '0;
            grid_space_reg <= POS_W'(dhs_pkg::GRID_SPACE_RST);
            mc_offset_reg <= '0;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            err_clr_reg <= 1'b0;
            move_cmd_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            err_clr_reg <= 1'b0;
            move_cmd_reg <= 1'b0;
            if (wr_pend_reg) begin
                case (addr_reg)
                    dhs_pkg::OFS_CTRL: begin
                        start_reg <= hwdata_i[dhs_pkg::CTRL_START_BIT];
                        abort_reg <= hwdata_i[dhs_pkg::CTRL_ABORT_BIT];
                        err_clr_reg <= hwdata_i[dhs_pkg::CTRL_ERR_CLR_BIT];
                        cfg_reg.dir_neg <= hwdata_i[dhs_pkg::CTRL_DIR_BIT];
                        cfg_reg.noref <= hwdata_i[dhs_pkg::CTRL_NOREF_BIT];
                        cfg_reg.high_speed_sel <= hwdata_i[dhs_pkg::CTRL_HIGHSPEED_BIT];
                        cfg_reg.grid_report_select <= hwdata_i[dhs_pkg::CTRL_GRID_SEL_BIT];
                    end
                    dhs_pkg::OFS_RAPID: rapid_reg <= hwdata_i[SPD_W-1:0];
                    dhs_pkg::OFS_HOME_RAPID: home_rapid_reg <= hwdata_i[SPD_W-1:0];
                    dhs_pkg::OFS_APPROACH: approach_reg <= hwdata_i[SPD_W-1:0];
                    dhs_pkg::OFS_SHIFT: shift_reg <= hwdata_i[POS_W-1:0];
                    dhs_pkg::OFS_MASK: mask_reg <= hwdata_i[POS_W-1:0];
                    dhs_pkg::OFS_GRID_SPACE: grid_space_reg <= hwdata_i[POS_W-1:0];
                    dhs_pkg::OFS_MC_OFFSET: mc_offset_reg <= hwdata_i[POS_W-1:0];
                    dhs_pkg::OFS_MOVE_CMD: move_cmd_reg <= hwdata_i[0];
                    default: ;
                endcase
            end
        end
    end

    // Read data is registered from the address phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (bus_take && !hwrite_i) begin
            case (haddr_i[7:0])
                dhs_pkg::OFS_CTRL: hrdata_reg <= 32'({cfg_reg.grid_report_select, 1'b0,
                    cfg_reg.high_speed_sel, cfg_reg.noref, cfg_reg.dir_neg, 2'b00});
                dhs_pkg::OFS_RAPID: hrdata_reg <= 32'(rapid_reg);
                dhs_pkg::OFS_HOME_RAPID: hrdata_reg <= 32'(home_rapid_reg);
                dhs_pkg::OFS_APPROACH: hrdata_reg <= 32'(approach_reg);
                dhs_pkg::OFS_SHIFT: hrdata_reg <= 32'(shift_reg);
                dhs_pkg::OFS_MASK: hrdata_reg <= 32'(mask_reg);
                dhs_pkg::OFS_GRID_SPACE: hrdata_reg <= 32'(grid_space_reg);
                dhs_pkg::OFS_MC_OFFSET: hrdata_reg <= 32'(mc_offset_reg);
                dhs_pkg::OFS_STATUS: hrdata_reg <= 32'({(state_reg != dhs_pkg::DHS_IDLE),
                    prog_err_reg, homed_reg, (state_reg != dhs_pkg::DHS_IDLE)});
                dhs_pkg::OFS_GRID_AMOUNT: hrdata_reg <= 32'(grid_amount_reg);
                dhs_pkg::OFS_MACHINE_POS: hrdata_reg <= 32'(machine_pos_reg);
                default: hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata_o = hrdata_reg;

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dog_meta_reg <= 1'b0;
            dog_sync_reg <= 1'b0;
            dog_prev_reg <= 1'b0;
            z_meta_reg <= 1'b0;
            z_sync_reg <= 1'b0;
            z_prev_reg <= 1'b0;
        end else begin
            dog_meta_reg <= dog_i;
            dog_sync_reg <= dog_meta_reg;
            dog_prev_reg <= dog_sync_reg;
            z_meta_reg <= zphase_i;
            z_sync_reg <= z_meta_reg;
            z_prev_reg <= z_sync_reg;
        end
    end

    assign z_rise = z_sync_reg && !z_prev_reg;
    assign dog_fall = !dog_sync_reg && dog_prev_reg;
    assign fb_delta = fb_pos_i - last_fb_reg;
    assign step_abs = cfg_reg.dir_neg ? (POS_W'(0) - fb_delta) : fb_delta;
    assign travel = rel_pos_reg - release_pos_reg;
    assign phase_sum = grid_phase_reg + step_abs;
    assign fast_left = ref_pos_reg - rel_pos_reg - step_abs - POS_W'(speed_cmd_o);

    // Grid points: Z-phase resyncs, spacing subdivides the revolution
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            grid_phase_reg <= '0;
            last_fb_reg <= '0;
            rel_pos_reg <= '0;
        end else begin
            last_fb_reg <= fb_pos_i;
            rel_pos_reg <= rel_pos_reg + step_abs;
            if (z_rise) begin
                grid_phase_reg <= '0;
            end else if (phase_sum >= grid_space_reg) begin
                grid_phase_reg <= phase_sum - grid_space_reg;
            end else begin
                grid_phase_reg <= phase_sum;
            end
        end
    end

    assign grid_hit = z_rise || (phase_sum >= grid_space_reg);

    // Homing sequence
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= dhs_pkg::DHS_IDLE;
            release_pos_reg <= '0;
            grid_amount_reg <= '0;
            ref_pos_reg <= '0;
        end else if (abort_reg) begin
            state_reg <= dhs_pkg::DHS_IDLE;
        end else begin
            case (state_reg)
                dhs_pkg::DHS_IDLE: begin
                    if (start_reg && !cfg_reg.noref) begin
                        if (homed_reg && cfg_reg.high_speed_sel) begin
                            state_reg <= dhs_pkg::DHS_FAST_RETURN;
                        end else begin
                            state_reg <= dhs_pkg::DHS_RAPID;
                        end
                    end
                end
                dhs_pkg::DHS_RAPID: begin
                    if (dog_sync_reg) begin
                        state_reg <= dhs_pkg::DHS_DECEL;
                    end
                end
                dhs_pkg::DHS_DECEL: begin
                    if (fb_delta == '0) begin
                        state_reg <= dhs_pkg::DHS_APPROACH;
                    end
                end
                dhs_pkg::DHS_APPROACH: begin
                    if (dog_fall) begin
                        release_pos_reg <= rel_pos_reg;
                        state_reg <= (mask_reg != '0) ? dhs_pkg::DHS_MASKED
                            : dhs_pkg::DHS_SEEK_GRID;
                    end
                end
                dhs_pkg::DHS_MASKED: begin
                    if (travel >= mask_reg) begin
                        state_reg <= dhs_pkg::DHS_SEEK_GRID;
                    end
                end
                dhs_pkg::DHS_SEEK_GRID: begin
                    if (grid_hit) begin
                        if (cfg_reg.grid_report_select) begin
                            grid_amount_reg <= travel - mask_reg;
                        end else begin
                            grid_amount_reg <= travel;
                        end
                        ref_pos_reg <= rel_pos_reg + shift_reg;
                        state_reg <= (shift_reg != '0) ? dhs_pkg::DHS_SHIFT
                            : dhs_pkg::DHS_DONE;
                    end
                end
                dhs_pkg::DHS_SHIFT: begin
                    if (rel_pos_reg >= ref_pos_reg) begin
                        state_reg <= dhs_pkg::DHS_DONE;
                    end
                end
                dhs_pkg::DHS_FAST_RETURN: begin
                    if (fast_left == '0) begin
                        state_reg <= dhs_pkg::DHS_DONE;
                    end
                end
                dhs_pkg::DHS_DONE: state_reg <= dhs_pkg::DHS_IDLE;
                default: state_reg <= dhs_pkg::DHS_IDLE;
            endcase
        end
    end

    // Homed flag and machine coordinates
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            homed_reg <= 1'b0;
            machine_pos_reg <= '0;
        end else if (state_reg == dhs_pkg::DHS_DONE && !abort_reg) begin
            homed_reg <= 1'b1;
            machine_pos_reg <= mc_offset_reg;
        end else begin
            machine_pos_reg <= machine_pos_reg + fb_delta;
        end
    end

    // Program error: set wins over clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prog_err_reg <= 1'b0;
        end else if (move_cmd_reg && !homed_reg && !cfg_reg.noref) begin
            prog_err_reg <= 1'b1;
        end else if (err_clr_reg) begin
            prog_err_reg <= 1'b0;
        end
    end

    // Motion command outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            speed_cmd_o <= '0;
            dir_neg_o <= 1'b0;
            pos_target_o <= '0;
            pos_mode_o <= 1'b0;
            homed_o <= 1'b0;
            prog_err_o <= 1'b0;
        end else begin
            homed_o <= homed_reg;
            prog_err_o <= prog_err_reg;
            dir_neg_o <= cfg_reg.dir_neg;
            pos_target_o <= ref_pos_reg;
            pos_mode_o <= (state_reg == dhs_pkg::DHS_FAST_RETURN);
            case (state_reg)
                dhs_pkg::DHS_RAPID: speed_cmd_o <= home_rapid_reg;
                dhs_pkg::DHS_APPROACH, dhs_pkg::DHS_MASKED, dhs_pkg::DHS_SEEK_GRID,
                dhs_pkg::DHS_SHIFT: speed_cmd_o <= approach_reg;
                dhs_pkg::DHS_FAST_RETURN: speed_cmd_o <= (fast_left < POS_W'(rapid_reg))
                    ? fast_left[SPD_W-1:0] : rapid_reg;
                default: speed_cmd_o <= '0;
            endcase
        end
    end

endmodule : dhs_homing_sequencer

// ---- dv/dhs_homing_sequencer_asserts.sv ----
// Checker for the homing sequencer: bus answer, start, dog stop, rates, errors.
// Assumes a bind to the top module, one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module dhs_homing_sequencer_asserts #(
    parameter int unsigned POS_W = dhs_pkg::POS_W,
    parameter int unsigned SPD_W = dhs_pkg::SPD_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic dog_i,
    input wire logic [SPD_W-1:0] speed_cmd_o,
    input wire logic dir_neg_o,
    input wire logic pos_mode_o,
    input wire logic [POS_W-1:0] pos_target_o,
    input wire logic homed_o,
    input wire logic prog_err_o
);
    logic ap_wr;
    logic [7:0] ap_a;
    logic dir_q;
    logic [SPD_W-1:0] rap_q;
    logic [SPD_W-1:0] hrap_q;
    logic [SPD_W-1:0] appr_q;
    logic wr_dp;
    assign wr_dp = ap_wr && hready_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow of the write address phase and of the written settings
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ap_wr <= 1'b0;
            ap_a <= 8'h00;
        end else if (hready_i) begin
            ap_wr <= hsel_i && (htrans_i == dhs_pkg::HTRANS_NONSEQ) && hwrite_i;
            ap_a <= haddr_i[7:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir_q <= 1'b0;
            rap_q <= SPD_W'(dhs_pkg::RAPID_RST);
            hrap_q <= SPD_W'(dhs_pkg::HOME_RAPID_RST);
            appr_q <= SPD_W'(dhs_pkg::APPROACH_RST);
        end else if (wr_dp) begin
            if (ap_a == dhs_pkg::OFS_CTRL) dir_q <= hwdata_i[dhs_pkg::CTRL_DIR_BIT];
            if (ap_a == dhs_pkg::OFS_RAPID) rap_q <= hwdata_i[SPD_W-1:0];
            if (ap_a == dhs_pkg::OFS_HOME_RAPID) hrap_q <= hwdata_i[SPD_W-1:0];
            if (ap_a == dhs_pkg::OFS_APPROACH) appr_q <= hwdata_i[SPD_W-1:0];
        end
    end
    a_ready_high: assert property (hreadyout_o)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp_o)
        else $error("error response");
    a_reset_clear: assert property ($rose(rst_n_i) |-> speed_cmd_o == '0 && !homed_o)
        else $error("outputs not cleared by reset");
    a_unhomed_move: assert property (wr_dp && ap_a == dhs_pkg::OFS_MOVE_CMD && hwdata_i[0]
        && !homed_o |-> ##[1:3] prog_err_o)
        else $error("unhomed move without program error");
    a_homed_kept: assert property ($past(rst_n_i) |-> !$fell(homed_o))
        else $error("reference lost without reset");
    a_fast_homed: assert property (pos_mode_o |-> homed_o)
        else $error("high-speed return before first homing");
    a_fast_rate: assert property (pos_mode_o && speed_cmd_o != rap_q |=> speed_cmd_o == '0)
        else $error("high-speed return not at rapid rate");
    a_target_steady: assert property (pos_mode_o && $past(pos_mode_o)
        |-> $stable(pos_target_o))
        else $error("reference target moved during high-speed return");
    a_start_rapid: assert property (wr_dp && ap_a == dhs_pkg::OFS_CTRL
        && hwdata_i[dhs_pkg::CTRL_START_BIT] && !hwdata_i[dhs_pkg::CTRL_NOREF_BIT]
        && (!hwdata_i[dhs_pkg::CTRL_HIGHSPEED_BIT] || !homed_o) && !dog_i
        |-> ##[1:6] speed_cmd_o == hrap_q)
        else $error("dog homing not at homing rapid rate");
    a_dog_stop: assert property ($rose(dog_i) && !pos_mode_o && speed_cmd_o == hrap_q
        |-> ##[1:6] speed_cmd_o == '0)
        else $error("no stop on dog");
    a_approach_dir: assert property (!pos_mode_o && speed_cmd_o == appr_q
        && appr_q != hrap_q |-> dir_neg_o == dir_q)
        else $error("approach direction wrong");
    c_homed: cover property ($rose(homed_o));
    c_fast: cover property ($rose(pos_mode_o));
    c_err: cover property ($rose(prog_err_o));
endmodule : dhs_homing_sequencer_asserts

bind dhs_homing_sequencer dhs_homing_sequencer_asserts #(.POS_W(POS_W), .SPD_W(SPD_W)) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .dog_i(dog_i),
    .speed_cmd_o(speed_cmd_o), .dir_neg_o(dir_neg_o), .pos_mode_o(pos_mode_o),
    .pos_target_o(pos_target_o),
    .homed_o(homed_o), .prog_err_o(prog_err_o)
);

// ---- dv/dhs_axis_model.sv ----
// Axis model: servo integrates the speed command, dog switch and encoder Z pulse.
// Assumes speed is counts per clock; park places the axis for the next test.
`timescale 1ns/1ns
module dhs_axis_model #(
    parameter logic [31:0] DOG_LO = 32'h0000_3000,
    parameter logic [31:0] DOG_HI = 32'h0000_5000,
    parameter logic [31:0] Z_OFS = 32'h0000_0800,
    parameter int unsigned Z_SH = 12
) (
    input wire logic clk_i,
    input wire logic park_i,
    input wire logic [31:0] park_pos_i,
    input wire logic [15:0] speed_i,
    input wire logic dir_neg_i,
    output logic [31:0] pos_o,
    output logic dog_o,
    output logic zphase_o
);
    logic [31:0] nxt;
    assign nxt = dir_neg_i ? pos_o - 32'(speed_i) : pos_o + 32'(speed_i);
    assign dog_o = (pos_o >= DOG_LO) && (pos_o < DOG_HI);
    initial pos_o = 32'h0;
    initial zphase_o = 1'b0;
    always @(posedge clk_i) begin
        pos_o <= park_i ? park_pos_i : nxt;
        // One pulse each revolution, at the zero of the Z phase
        zphase_o <= !park_i && ((nxt - Z_OFS) >> Z_SH) != ((pos_o - Z_OFS) >> Z_SH);
    end
endmodule : dhs_axis_model

// ---- dv/test_dog_type_homing_sequencer.sv ----
// Bench for the homing sequencer: AHB-Lite tasks, axis model, queued read checks.
// Assumes the checker is bound to the design and hreadyout is fed back as hready.
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_dog_type_homing_sequencer;
    typedef struct packed {logic [31:0] e; logic [31:0] t;} dhs_tb_exp_t;
    typedef struct packed {
        logic [31:0] p; logic [31:0] ctl; logic [31:0] mask;
        logic [31:0] shift; logic [31:0] stop; logic [31:0] grid;
    } dhs_tb_case_t;
    // Dog release sits half a grid from the next Z pulse
    localparam dhs_tb_case_t CASES [4] = '{
        '{32'h0, 32'h0, 32'h0, 32'h0, 32'h5800, 32'h0800},
        '{32'h0, 32'h0, 32'h0A00, 32'h0100, 32'h6900, 32'h1800},
        '{32'h0, 32'h40, 32'h0A00, 32'h0, 32'h6800, 32'h0E00},
        '{32'h9000, 32'h4, 32'h0, 32'h0, 32'h2800, 32'h0800}};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic park = 1'b1;
    logic [31:0] park_pos = 32'h0;
    logic rd_ph = 1'b0;
    logic saw_fast = 1'b0;
    logic [31:0] last_rd;
    logic [31:0] moff;
    logic [31:0] hrdata, fb_pos, pos_target;
    logic [15:0] speed;
    logic hreadyout, hresp, dog, zph, dir_neg, pos_mode, homed, prog_err;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    dhs_tb_exp_t expq[$];
    initial forever #10 clk_i = ~clk_i;
    dhs_homing_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .dog_i(dog), .zphase_i(zph),
        .fb_pos_i(fb_pos), .speed_cmd_o(speed), .dir_neg_o(dir_neg),
        .pos_target_o(pos_target), .pos_mode_o(pos_mode), .homed_o(homed),
        .prog_err_o(prog_err));
    dhs_axis_model u_axis (.clk_i(clk_i), .park_i(park), .park_pos_i(park_pos),
        .speed_i(speed), .dir_neg_i(dir_neg), .pos_o(fb_pos), .dog_o(dog), .zphase_o(zph));
    function automatic logic near(input logic [31:0] g, input logic [31:0] e,
        input logic [31:0] t);
        return (g - e + t) <= (t << 1);
    endfunction : near
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i) begin : mon
        dhs_tb_exp_t n;
        logic [31:0] g;
        cyc++;
        if (pos_mode === 1'b1) saw_fast <= 1'b1;
        if (rd_ph && hreadyout === 1'b1 && expq.size() > 0) begin
            n = expq.pop_front();
            g = near(hrdata, n.e, n.t) ? n.e : hrdata;
            `CHK(g, n.e)
        end
        if (cyc == 40000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic c);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= dhs_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= c;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        last_rd = hrdata;
        rd_ph <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] t);
        expq.push_back('{e, t});
        bus(a, 1'b0, 32'h0, 1'b1);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 1'b0);
    endtask : wr
    task automatic home(input logic [31:0] p, input logic [31:0] ctl,
        input logic [31:0] mask, input logic [31:0] shift);
        int n;
        n = 0;
        park_pos <= p;
        park <= 1'b1;
        @(posedge clk_i);
        park <= 1'b0;
        wr(dhs_pkg::OFS_MASK, mask);
        wr(dhs_pkg::OFS_SHIFT, shift);
        wr(dhs_pkg::OFS_CTRL, ctl | 32'h1);
        do begin
            bus(dhs_pkg::OFS_STATUS, 1'b0, 32'h0, 1'b0);
            n++;
        end while ((last_rd[dhs_pkg::ST_BUSY_BIT] !== 1'b0 || n < 4) && n < 5000);
    endtask : home
    task automatic rst_pulse();
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK(homed, 1'b0)
        `CHK(speed, 16'h0)
    endtask : rst_pulse
    initial begin
        void'($urandom(32'h9B6E));
        moff = $urandom & 32'h0000_FFFF;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        park <= 1'b0;
        rd(dhs_pkg::OFS_CTRL, dhs_pkg::CTRL_RST, 32'h0);
        rd(dhs_pkg::OFS_RAPID, {16'h0, dhs_pkg::RAPID_RST}, 32'h0);
        rd(dhs_pkg::OFS_HOME_RAPID, {16'h0, dhs_pkg::HOME_RAPID_RST}, 32'h0);
        rd(dhs_pkg::OFS_APPROACH, {16'h0, dhs_pkg::APPROACH_RST}, 32'h0);
        rd(dhs_pkg::OFS_GRID_SPACE, dhs_pkg::GRID_SPACE_RST, 32'h0);
        rd(dhs_pkg::OFS_STATUS, 32'h0, 32'h0);
        rd(8'h30, 32'h0, 32'h0);
        wr(dhs_pkg::OFS_MC_OFFSET, moff);
        rd(dhs_pkg::OFS_MC_OFFSET, moff, 32'h0);
        $display("test registers done");
        wr(dhs_pkg::OFS_MOVE_CMD, 32'h1);
        repeat (4) @(posedge clk_i);
        `CHK(prog_err, 1'b1)
        rd(dhs_pkg::OFS_STATUS, 32'h4, 32'h0);
        wr(dhs_pkg::OFS_CTRL, 32'h80);
        rd(dhs_pkg::OFS_STATUS, 32'h0, 32'h0);
        wr(dhs_pkg::OFS_CTRL, 32'h9);
        repeat (20) @(posedge clk_i);
        `CHK(speed, 16'h0)
        `CHK(homed, 1'b0)
        wr(dhs_pkg::OFS_CTRL, 32'h0);
        $display("test error and noref done");
        for (int i = 0; i < 4; i++) begin
            home(CASES[i].p, CASES[i].ctl, CASES[i].mask, CASES[i].shift);
            `CHK(near(fb_pos, CASES[i].stop, 32'h40), 1'b1)
            `CHK(homed, 1'b1)
            rd(dhs_pkg::OFS_GRID_AMOUNT, CASES[i].grid, 32'h40);
            if (i == 0) rd(dhs_pkg::OFS_MACHINE_POS, moff, 32'h40);
            $display("test homing case %0d done", i);
        end
        home(32'h9000, 32'h14, 32'h0, 32'h0);
        `CHK(saw_fast, 1'b1)
        `CHK(near(fb_pos, 32'h2800, 32'h40), 1'b1)
        wr(dhs_pkg::OFS_MOVE_CMD, 32'h1);
        repeat (4) @(posedge clk_i);
        `CHK(prog_err, 1'b0)
        rst_pulse();
        $display("test high-speed return done");
        wr(dhs_pkg::OFS_CTRL, 32'h1);
        repeat (40) @(posedge clk_i);
        rst_pulse();
        rd(dhs_pkg::OFS_STATUS, 32'h0, 32'h0);
        $display("test abort by reset done");
        wr(dhs_pkg::OFS_CTRL, 32'h1);
        repeat (10) @(posedge clk_i);
        wr(dhs_pkg::OFS_CTRL, 32'h2);
        repeat (3) @(posedge clk_i);
        `CHK(speed, 16'h0)
        rd(dhs_pkg::OFS_STATUS, 32'h0, 32'h0);
        $display("test abort command done");
        report_and_stop();
    end
endmodule : test_dog_type_homing_sequencer
